// file: verilog/lxtc_top.sv
// Control and status registers for line transceiver comparator and amplifier trim
// Behaviour
// - Mode bit per comparator and amplifier: 0 normal, 1 offset calibration; resets 0.
// - Comparator reference select: 0 negative input, 1 positive input; resets 0.
// - Comparator 5-bit trim in bits 4..0 drives cell; resets to 10000.
// - Output select forwards comparator 0 filtered output at 0, comparator 1 at 1.
// - Polarity bit passes comparator result straight at 0, inverted at 1.
// - 2-bit hysteresis fields: comparator 1 bits 3..2, comparator 0 bits 1..0.
// - Amplifier enable 1 turns it on; 0 off with output high impedance.
// - Amplifier status reads output state in calibration mode, else reads 0.
// - Bandwidth bit 0 picks 600kHz at 0, 2MHz at 1; resets 0.
// - Amplifier 6-bit trim bits 5..0 resets 100000; bit 6 reference select.
// - Unimplemented bits ignore writes and read as zero.
// - Disabled comparator status forced to 0, or to 1 when inverted.
// - Filtered output asserts only when current and previous N samples agree active.
module lxtc_top
   import lxtc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [7:0] regRdData,
   input wire logic cmp0RawOut,
   input wire logic cmp1RawOut,
   input wire logic ampRawOut,
   output logic cmp0CalMode,
   output logic cmp1CalMode,
   output logic cmp0CalRefSel,
   output logic cmp1CalRefSel,
   output logic [4:0] cmp0Trim,
   output logic [4:0] cmp1Trim,
   output logic [1:0] cmp0HystWindow,
   output logic [1:0] cmp1HystWindow,
   output logic cmp0Enable,
   output logic cmp1Enable,
   output logic cmpSharedOut,
   output logic ampEnable,
   output logic ampOutputHiZ,
   output logic ampBandwidthSel,
   output logic ampCalMode,
   output logic ampCalRefSel,
   output logic [5:0] ampTrim
);
   // Register storage
   logic cmp0Mode_ff;
   logic cmp1Mode_ff;
   logic cmp0Ref_ff;
   logic cmp1Ref_ff;
   logic [4:0] cmp0Trim_ff;
   logic [4:0] cmp1Trim_ff;
   logic outSel_ff;
   logic cmp0Inv_ff;
   logic cmp1Inv_ff;
   logic [1:0] cmp0Hyst_ff;
   logic [1:0] cmp1Hyst_ff;
   // Amplifier control and trim
   logic ampEn_ff;
   logic ampHiZ_ff;
   logic ampBw_ff;
   logic ampMode_ff;
   logic ampRef_ff;
   logic [5:0] ampTrim_ff;
   // Comparator enables and debounce selects
   logic cmp0En_ff;
   logic cmp1En_ff;
   logic [1:0] cmp0Deb_ff;
   logic [1:0] cmp1Deb_ff;
   // Read data, shared output and amplifier synchroniser
   logic [7:0] rdData_ff;
   logic shared_ff;
   logic [2:0] ampSync_ff;
   logic ampStable_ff;

   // Status from the comparator filters
   logic cmp0Status;
   logic cmp1Status;
   logic cmp0Filt;
   logic cmp1Filt;

   // Address decode
   logic wrCmp0;
   logic wrCmp1;
   logic wrPolHys;
   logic wrAmpCtrl;
   logic wrAmpTrim;
   logic wrCmpCtrl;
   logic ampStatus;
   logic [7:0] rdCmp0;
   logic [7:0] rdCmp1;
   logic [7:0] rdPolHys;
   logic [7:0] rdAmpCtrl;
   logic [7:0] rdAmpTrim;
   logic [7:0] rdCmpCtrl;
   logic [7:0] rdMux;
   logic [7:0] nxt_rdData;
   logic nxt_shared;

   assign wrCmp0 = regWrStb && (regAddr == LXTC_OFS_CMP0_TRIM);
   assign wrCmp1 = regWrStb && (regAddr == LXTC_OFS_CMP1_TRIM);
   assign wrPolHys = regWrStb && (regAddr == LXTC_OFS_CMP_POLHYS);
   assign wrAmpCtrl = regWrStb && (regAddr == LXTC_OFS_AMP_CTRL);
   assign wrAmpTrim = regWrStb && (regAddr == LXTC_OFS_AMP_TRIM);
   assign wrCmpCtrl = regWrStb && (regAddr == LXTC_OFS_CMP_CTRL);

   // Amplifier status is only visible in calibration mode
   assign ampStatus = ampMode_ff & ampStable_ff;

   // Read images; unimplemented bits are constant zero
   assign rdCmp0 = {1'b0, cmp0Mode_ff, cmp0Ref_ff, cmp0Trim_ff};
   assign rdCmp1 = {1'b0, cmp1Mode_ff, cmp1Ref_ff, cmp1Trim_ff};
   assign rdPolHys = {1'b0, outSel_ff, cmp1Inv_ff, cmp0Inv_ff, cmp1Hyst_ff, cmp0Hyst_ff};
   assign rdAmpCtrl = {1'b0, ampEn_ff, ampStatus, 4'h0, ampBw_ff};
   assign rdAmpTrim = {ampMode_ff, ampRef_ff, ampTrim_ff};
   assign rdCmpCtrl = {cmp1Status, cmp0Status, cmp1Deb_ff, cmp0Deb_ff, cmp1En_ff, cmp0En_ff};

   // Read multiplexer; unmapped addresses read zero
   assign rdMux = (regAddr == LXTC_OFS_CMP0_TRIM) ? rdCmp0 :
                  (regAddr == LXTC_OFS_CMP1_TRIM) ? rdCmp1 :
                  (regAddr == LXTC_OFS_CMP_POLHYS) ? rdPolHys :
                  (regAddr == LXTC_OFS_AMP_CTRL) ? rdAmpCtrl :
                  (regAddr == LXTC_OFS_AMP_TRIM) ? rdAmpTrim :
                  (regAddr == LXTC_OFS_CMP_CTRL) ? rdCmpCtrl : 8'h00;

   // Read data is presented only in the cycle after a read strobe
   assign nxt_rdData = regRdStb ? rdMux : 8'h00;

   // Shared comparator output source
   assign nxt_shared = outSel_ff ? cmp1Filt : cmp0Filt;

   // Comparator 0 trim register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmp0Mode_ff <= 1'b0;
         cmp0Ref_ff <= 1'b0;
         cmp0Trim_ff <= LXTC_CMP_TRIM_RST;
      end else if (wrCmp0) begin
         cmp0Mode_ff <= regWrData[LXTC_CT_MODE_BIT];
         cmp0Ref_ff <= regWrData[LXTC_CT_REF_BIT];
         cmp0Trim_ff <= regWrData[4:0];
      end
   end

   // Comparator 1 trim register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmp1Mode_ff <= 1'b0;
         cmp1Ref_ff <= 1'b0;
         cmp1Trim_ff <= LXTC_CMP_TRIM_RST;
      end else if (wrCmp1) begin
         cmp1Mode_ff <= regWrData[LXTC_CT_MODE_BIT];
         cmp1Ref_ff <= regWrData[LXTC_CT_REF_BIT];
         cmp1Trim_ff <= regWrData[4:0];
      end
   end

   // Polarity, output select and hysteresis register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         outSel_ff <= 1'b0;
         cmp1Inv_ff <= 1'b0;
         cmp0Inv_ff <= 1'b0;
         cmp1Hyst_ff <= 2'h0;
         cmp0Hyst_ff <= 2'h0;
      end else if (wrPolHys) begin
         outSel_ff <= regWrData[LXTC_PH_OSEL_BIT];
         cmp1Inv_ff <= regWrData[LXTC_PH_INV1_BIT];
         cmp0Inv_ff <= regWrData[LXTC_PH_INV0_BIT];
         cmp1Hyst_ff <= regWrData[3:2];
         cmp0Hyst_ff <= regWrData[1:0];
      end
   end

   // Amplifier control register; status bit is read only
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ampEn_ff <= 1'b0;
         ampHiZ_ff <= 1'b1;
         ampBw_ff <= 1'b0;
      end else if (wrAmpCtrl) begin
         ampEn_ff <= regWrData[LXTC_AC_EN_BIT];
         ampHiZ_ff <= ~regWrData[LXTC_AC_EN_BIT];
         ampBw_ff <= regWrData[LXTC_AC_BW_BIT];
      end
   end

   // Amplifier trim register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ampMode_ff <= 1'b0;
         ampRef_ff <= 1'b0;
         ampTrim_ff <= LXTC_AMP_TRIM_RST;
      end else if (wrAmpTrim) begin
         ampMode_ff <= regWrData[LXTC_AT_MODE_BIT];
         ampRef_ff <= regWrData[LXTC_AT_REF_BIT];
         ampTrim_ff <= regWrData[5:0];
      end
   end

   // Comparator enable and debounce register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmp0En_ff <= 1'b0;
         cmp1En_ff <= 1'b0;
         cmp0Deb_ff <= 2'h0;
         cmp1Deb_ff <= 2'h0;
      end else if (wrCmpCtrl) begin
         cmp0En_ff <= regWrData[LXTC_CC_EN0_BIT];
         cmp1En_ff <= regWrData[LXTC_CC_EN1_BIT];
         cmp0Deb_ff <= regWrData[LXTC_CC_DEB0_LSB +: 2];
         cmp1Deb_ff <= regWrData[LXTC_CC_DEB1_LSB +: 2];
      end
   end

   // Read data, valid the cycle after the strobe only
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdData_ff <= 8'h00;
      end else begin
         rdData_ff <= nxt_rdData;
      end
   end

   // Amplifier output synchroniser; change accepted when stages two and three agree
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ampSync_ff <= 3'h0;
         ampStable_ff <= 1'b0;
      end else begin
         ampSync_ff <= {ampSync_ff[1:0], ampRawOut};
         if (ampSync_ff[1] == ampSync_ff[2]) begin
            ampStable_ff <= ampSync_ff[2];
         end
      end
   end

   // Shared comparator output selection
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         shared_ff <= 1'b0;
      end else begin
         shared_ff <= nxt_shared;
      end
   end

   // Comparator 0 status and filter
   lxtc_debounce u_deb0 (
      .mclk(mclk),
      .rst(rst),
      .rawIn(cmp0RawOut),
      .enable(cmp0En_ff),
      .invert(cmp0Inv_ff),
      .debSel(cmp0Deb_ff),
      .status(cmp0Status),
      .filtered(cmp0Filt)
   );

   // Comparator 1 status and filter
   lxtc_debounce u_deb1 (
      .mclk(mclk),
      .rst(rst),
      .rawIn(cmp1RawOut),
      .enable(cmp1En_ff),
      .invert(cmp1Inv_ff),
      .debSel(cmp1Deb_ff),
      .status(cmp1Status),
      .filtered(cmp1Filt)
   );

   // Bus read data straight from its register
   assign regRdData = rdData_ff;

   // Comparator cell controls straight from registers
   assign cmp0CalMode = cmp0Mode_ff;
   assign cmp1CalMode = cmp1Mode_ff;
   assign cmp0CalRefSel = cmp0Ref_ff;
   assign cmp1CalRefSel = cmp1Ref_ff;
   assign cmp0Trim = cmp0Trim_ff;
   assign cmp1Trim = cmp1Trim_ff;
   assign cmp0HystWindow = cmp0Hyst_ff;
   assign cmp1HystWindow = cmp1Hyst_ff;
   assign cmp0Enable = cmp0En_ff;
   assign cmp1Enable = cmp1En_ff;
   assign cmpSharedOut = shared_ff;

   // Amplifier cell controls straight from registers
   assign ampEnable = ampEn_ff;
   assign ampOutputHiZ = ampHiZ_ff;
   assign ampBandwidthSel = ampBw_ff;
   assign ampCalMode = ampMode_ff;
   assign ampCalRefSel = ampRef_ff;
   assign ampTrim = ampTrim_ff;
endmodule

// file: verilog/lxtc_pkg.sv
// Package of register offsets, field positions and reset values for the line transceiver trim block
package lxtc_pkg;
   // Register offsets
   localparam logic [2:0] LXTC_OFS_CMP0_TRIM = 3'h0;
   localparam logic [2:0] LXTC_OFS_CMP1_TRIM = 3'h1;
   localparam logic [2:0] LXTC_OFS_CMP_POLHYS = 3'h2;
   localparam logic [2:0] LXTC_OFS_AMP_CTRL = 3'h3;
   localparam logic [2:0] LXTC_OFS_AMP_TRIM = 3'h4;
   localparam logic [2:0] LXTC_OFS_CMP_CTRL = 3'h5;
   // Comparator trim register fields
   localparam int LXTC_CT_MODE_BIT = 6;
   localparam int LXTC_CT_REF_BIT = 5;
   localparam logic [4:0] LXTC_CMP_TRIM_RST = 5'h10;
   // Polarity and hysteresis fields
   localparam int LXTC_PH_OSEL_BIT = 6;
   localparam int LXTC_PH_INV1_BIT = 5;
   localparam int LXTC_PH_INV0_BIT = 4;
   // Amplifier control fields
   localparam int LXTC_AC_EN_BIT = 6;
   localparam int LXTC_AC_STAT_BIT = 5;
   localparam int LXTC_AC_BW_BIT = 0;
   // Amplifier trim fields
   localparam int LXTC_AT_MODE_BIT = 7;
   localparam int LXTC_AT_REF_BIT = 6;
   localparam logic [5:0] LXTC_AMP_TRIM_RST = 6'h20;
   // Comparator control fields: enables and debounce selects
   localparam int LXTC_CC_EN0_BIT = 0;
   localparam int LXTC_CC_EN1_BIT = 1;
   localparam int LXTC_CC_DEB0_LSB = 2;
   localparam int LXTC_CC_DEB1_LSB = 4;
   localparam int LXTC_CC_RES0_BIT = 6;
   localparam int LXTC_CC_RES1_BIT = 7;
   // Debounce sample periods in system clocks
   localparam logic [6:0] LXTC_DEB_PER1 = 7'h20;
   localparam logic [6:0] LXTC_DEB_PER2 = 7'h40;
   localparam logic [6:0] LXTC_DEB_PER3 = 7'h7f;
   // Debounce sample count N
   localparam int LXTC_DEB_SAMPLES = 3;
endpackage

// file: verilog/lxtc_debounce.sv
// Comparator status synchroniser and sample-agreement debounce
module lxtc_debounce
   import lxtc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic rawIn,
   input wire logic enable,
   input wire logic invert,
   input wire logic [1:0] debSel,
   output logic status,
   output logic filtered
);
   logic [2:0] sync_ff;
   logic stable_ff;
   logic [6:0] div_ff;
   logic [LXTC_DEB_SAMPLES-1:0] hist_ff;
   logic filt_ff;
   logic [6:0] period;
   logic divEnd;
   logic [6:0] nxt_div;
   logic level;
   logic activeLvl;
   logic allActive;
   logic [LXTC_DEB_SAMPLES:0] activeVec;

   // Sample period selection from the debounce field
   assign period = (debSel == 2'h1) ? LXTC_DEB_PER1 : (debSel == 2'h2) ? LXTC_DEB_PER2 : LXTC_DEB_PER3;
   assign divEnd = (debSel == 2'h0) || (div_ff >= period - 7'h1);
   assign nxt_div = divEnd ? 7'h0 : div_ff + 7'h1;
   // Disabled comparator forces 0 before inversion
   assign level = (enable ? stable_ff : 1'b0) ^ invert;
   assign activeLvl = ~invert;
   assign activeVec = {hist_ff[LXTC_DEB_SAMPLES-1:0], level};
   assign allActive = activeLvl ? (&activeVec) : ~(|activeVec);

   // Three-stage synchroniser; change accepted when stages two and three agree
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync_ff <= 3'h0;
         stable_ff <= 1'b0;
      end else begin
         sync_ff <= {sync_ff[1:0], rawIn};
         if (sync_ff[1] == sync_ff[2]) begin
            stable_ff <= sync_ff[2];
         end
      end
   end

   // History of status samples and filtered output
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_ff <= 7'h0;
         hist_ff <= '0;
         filt_ff <= 1'b0;
      end else begin
         div_ff <= nxt_div;
         if (divEnd) begin
            hist_ff <= activeVec[LXTC_DEB_SAMPLES-1:0];
            filt_ff <= allActive ? activeLvl : ~activeLvl;
         end
      end
   end

   assign status = level;
   assign filtered = filt_ff;
endmodule

// file: bench/lxtc_analog_model.sv
// Behavioural comparator and amplifier cells seen from the trim block
module lxtc_analog_model
   import lxtc_pkg::*;
#(
   parameter logic [4:0] TH0 = 5'h0d,
   parameter logic [4:0] TH1 = 5'h16,
   parameter logic [5:0] THA = 6'h29
)
(
   input wire logic mclk,
   input wire logic cmp0CalMode,
   input wire logic cmp1CalMode,
   input wire logic cmp0CalRefSel,
   input wire logic cmp1CalRefSel,
   input wire logic [4:0] cmp0Trim,
   input wire logic [4:0] cmp1Trim,
   input wire logic ampEnable,
   input wire logic ampCalMode,
   input wire logic ampCalRefSel,
   input wire logic [5:0] ampTrim,
   output logic cmp0RawOut,
   output logic cmp1RawOut,
   output logic ampRawOut
);
   timeunit 1ns;
   timeprecision 1ps;
   logic noise = 1'b0;
   // Line activity outside calibration changes every cycle
   always @(posedge mclk) noise <= ~noise;
   // Shorted inputs: output crosses where the trim cancels the offset
   assign cmp0RawOut = (cmp0CalMode && cmp0CalRefSel) ? (cmp0Trim >= TH0) : noise;
   assign cmp1RawOut = (cmp1CalMode && cmp1CalRefSel) ? (cmp1Trim >= TH1) : noise;
   // A disabled amplifier floats, so its state wanders
   assign ampRawOut = (ampEnable && ampCalMode && ampCalRefSel) ? (ampTrim >= THA) : noise;
endmodule

// file: bench/lxtc_top_assertions.sv
// Port-level checker of the trim register block
module lxtc_top_assertions
   import lxtc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [7:0] regRdData,
   input wire logic cmp0CalMode,
   input wire logic cmp1CalMode,
   input wire logic cmp0CalRefSel,
   input wire logic cmp1CalRefSel,
   input wire logic [4:0] cmp0Trim,
   input wire logic [4:0] cmp1Trim,
   input wire logic [1:0] cmp0HystWindow,
   input wire logic [1:0] cmp1HystWindow,
   input wire logic cmp0Enable,
   input wire logic cmp1Enable,
   input wire logic ampEnable,
   input wire logic ampOutputHiZ,
   input wire logic ampBandwidthSel,
   input wire logic ampCalMode,
   input wire logic ampCalRefSel,
   input wire logic [5:0] ampTrim
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Bus strobes at one offset
   sequence wr_at(logic [2:0] a);
      regWrStb && regAddr == a;
   endsequence
   sequence rd_at(logic [2:0] a);
      regRdStb && regAddr == a;
   endsequence
   hiz_follows_en_a: assert property (ampOutputHiZ == !ampEnable) else $error("hiz wrong");
   rd_idle_zero_a: assert property (!regRdStb |=> regRdData == 8'h00) else $error("idle data");
   cmp0_fields_a: assert property (wr_at(LXTC_OFS_CMP0_TRIM) |=> cmp0Trim == $past(regWrData[4:0])
      && cmp0CalMode == $past(regWrData[6]) && cmp0CalRefSel == $past(regWrData[5])) else $error("cmp0 fields");
   cmp1_trim_a: assert property (wr_at(LXTC_OFS_CMP1_TRIM) |=> cmp1Trim == $past(regWrData[4:0])
      && cmp1CalMode == $past(regWrData[6]) && cmp1CalRefSel == $past(regWrData[5])) else $error("cmp1 trim");
   cmp_enable_a: assert property (wr_at(LXTC_OFS_CMP_CTRL) |=> cmp0Enable == $past(regWrData[0])
      && cmp1Enable == $past(regWrData[1])) else $error("cmp enable");
   hyst_fields_a: assert property (wr_at(LXTC_OFS_CMP_POLHYS)
      |=> {cmp1HystWindow, cmp0HystWindow} == $past(regWrData[3:0])) else $error("hyst");
   amp_trim_a: assert property (wr_at(LXTC_OFS_AMP_TRIM) |=> ampTrim == $past(regWrData[5:0])
      && ampCalMode == $past(regWrData[7]) && ampCalRefSel == $past(regWrData[6])) else $error("amp trim");
   amp_ctrl_a: assert property (wr_at(LXTC_OFS_AMP_CTRL) |=> ampBandwidthSel == $past(regWrData[0])
      && ampEnable == $past(regWrData[6])) else $error("amp ctrl");
   trim_holds_a: assert property (!(regWrStb && regAddr == LXTC_OFS_CMP0_TRIM) |=> $stable(cmp0Trim))
      else $error("trim moved");
   trim_rsvd_a: assert property (rd_at(LXTC_OFS_CMP0_TRIM) |=> regRdData[7] == 1'b0) else $error("bit7");
   amp_rsvd_a: assert property (rd_at(LXTC_OFS_AMP_CTRL) |=> regRdData[4:1] == 4'h0) else $error("rsvd");
   amp_stat_off_a: assert property (rd_at(LXTC_OFS_AMP_CTRL) ##0 (!ampCalMode && !$past(ampCalMode))
      |=> regRdData[5] == 1'b0) else $error("amp status");
endmodule
bind lxtc_top lxtc_top_assertions chk (
   .mclk(mclk),
   .rst(rst),
   .regAddr(regAddr),
   .regWrData(regWrData),
   .regWrStb(regWrStb),
   .regRdStb(regRdStb),
   .regRdData(regRdData),
   .cmp0CalMode(cmp0CalMode),
   .cmp1CalMode(cmp1CalMode),
   .cmp0CalRefSel(cmp0CalRefSel),
   .cmp1CalRefSel(cmp1CalRefSel),
   .cmp0Trim(cmp0Trim),
   .cmp1Trim(cmp1Trim),
   .cmp0HystWindow(cmp0HystWindow),
   .cmp1HystWindow(cmp1HystWindow),
   .cmp0Enable(cmp0Enable),
   .cmp1Enable(cmp1Enable),
   .ampEnable(ampEnable),
   .ampOutputHiZ(ampOutputHiZ),
   .ampBandwidthSel(ampBandwidthSel),
   .ampCalMode(ampCalMode),
   .ampCalRefSel(ampCalRefSel),
   .ampTrim(ampTrim)
);

// file: bench/tb_lxtc_top.sv
// Self-checking bench for the trim and calibration register block
module tb_lxtc_top
   import lxtc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [5:0] TH0 = 6'h0d, TH1 = 6'h16, THA = 6'h29;
   logic mclk = 1'b0, rst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0, rdLate = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00, regRdData, d;
   logic cmp0RawOut, cmp1RawOut, ampRawOut, cmp0CalMode, cmp1CalMode, cmp0CalRefSel, cmp1CalRefSel;
   logic [4:0] cmp0Trim, cmp1Trim;
   logic [1:0] cmp0HystWindow, cmp1HystWindow;
   logic cmp0Enable, cmp1Enable, cmpSharedOut, ampEnable, ampOutputHiZ, ampBandwidthSel, ampCalMode, ampCalRefSel;
   logic [5:0] ampTrim;
   logic [7:0] notes[$];
   logic [7:0] rv[8] = '{8'h10, 8'h10, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
   logic [7:0] mk[8] = '{8'h7f, 8'h7f, 8'h7f, 8'h41, 8'hff, 8'h00, 8'h00, 8'h00};
   int failures = 0, check_count = 0;
   int debPeriod;
   always #5 mclk = ~mclk;
   lxtc_top dut (
      .mclk(mclk),
      .rst(rst),
      .regAddr(regAddr),
      .regWrData(regWrData),
      .regWrStb(regWrStb),
      .regRdStb(regRdStb),
      .regRdData(regRdData),
      .cmp0RawOut(cmp0RawOut),
      .cmp1RawOut(cmp1RawOut),
      .ampRawOut(ampRawOut),
      .cmp0CalMode(cmp0CalMode),
      .cmp1CalMode(cmp1CalMode),
      .cmp0CalRefSel(cmp0CalRefSel),
      .cmp1CalRefSel(cmp1CalRefSel),
      .cmp0Trim(cmp0Trim),
      .cmp1Trim(cmp1Trim),
      .cmp0HystWindow(cmp0HystWindow),
      .cmp1HystWindow(cmp1HystWindow),
      .cmp0Enable(cmp0Enable),
      .cmp1Enable(cmp1Enable),
      .cmpSharedOut(cmpSharedOut),
      .ampEnable(ampEnable),
      .ampOutputHiZ(ampOutputHiZ),
      .ampBandwidthSel(ampBandwidthSel),
      .ampCalMode(ampCalMode),
      .ampCalRefSel(ampCalRefSel),
      .ampTrim(ampTrim)
   );
   lxtc_analog_model #(.TH0(TH0[4:0]), .TH1(TH1[4:0]), .THA(THA)) far (
      .mclk(mclk),
      .cmp0CalMode(cmp0CalMode),
      .cmp1CalMode(cmp1CalMode),
      .cmp0CalRefSel(cmp0CalRefSel),
      .cmp1CalRefSel(cmp1CalRefSel),
      .cmp0Trim(cmp0Trim),
      .cmp1Trim(cmp1Trim),
      .ampEnable(ampEnable),
      .ampCalMode(ampCalMode),
      .ampCalRefSel(ampCalRefSel),
      .ampTrim(ampTrim),
      .cmp0RawOut(cmp0RawOut),
      .cmp1RawOut(cmp1RawOut),
      .ampRawOut(ampRawOut)
   );
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (failures == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One strobe cycle on the register port
   task automatic bus(input logic [2:0] a, input logic [7:0] v, input logic w);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= v;
      regWrStb <= w;
      regRdStb <= !w;
      @(posedge mclk);
      regWrStb <= 1'b0;
      regRdStb <= 1'b0;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      bus(a, v, 1'b1);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      notes.push_back(e);
      bus(a, 8'h00, 1'b0);
   endtask
   task automatic peek(input logic [2:0] a, output logic [7:0] v);
      bus(a, 8'h00, 1'b0);
      @(negedge mclk);
      v = regRdData;
   endtask
   // Trim write, settle through the synchroniser, read status
   task automatic step(input logic [2:0] a, input logic [7:0] t, input logic [2:0] sa, output logic [7:0] v);
      wr(a, t);
      repeat (8) @(posedge mclk);
      peek(sa, v);
   endtask
   // Software offset sweep up and down, then store the average
   task automatic cal(input logic [2:0] a, sa, input logic [7:0] ctl, input int sb, input logic [5:0] top, th);
      logic [7:0] v;
      logic [5:0] lo, hi;
      logic first;
      lo = 6'h00;
      step(a, ctl, sa, v);
      first = v[sb];
      while (v[sb] === first && lo < top) begin
         lo++;
         step(a, ctl | {2'h0, lo}, sa, v);
      end
      hi = top;
      step(a, ctl | {2'h0, hi}, sa, v);
      first = v[sb];
      while (v[sb] === first && hi > 6'h00) begin
         hi--;
         step(a, ctl | {2'h0, hi}, sa, v);
      end
      chk({2'h0, lo}, {2'h0, th});
      chk({2'h0, hi}, {2'h0, th - 6'h01});
      wr(a, ctl | {2'h0, 6'(({1'b0, lo} + {1'b0, hi}) >> 1)});
      rd(a, ctl | {2'h0, th - 6'h01});
   endtask
   // Read results are compared against the oldest note
   always @(posedge mclk) rdLate <= regRdStb;
   always @(negedge mclk) begin
      if (rdLate && notes.size() > 0) chk(regRdData, notes.pop_front());
   end
   initial begin
      #200us;
      failures++;
      stop_test();
   end
   initial begin
      void'($urandom(66));
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++) rd(3'(a), rv[a]);
      chk({7'h0, ampOutputHiZ}, 8'h01);
      // Random writes read back through each mask except the comparator control's, unmapped places included
      for (int i = 0; i < 20; i++) begin
         for (int a = 0; a < 8; a++) begin
            if (a == 5) continue;
            d = 8'($urandom);
            if (a == 4) d[7] = 1'b0;
            wr(3'(a), d);
            rd(3'(a), d & mk[a]);
         end
      end
      wr(LXTC_OFS_CMP_POLHYS, 8'h00);
      wr(LXTC_OFS_CMP_CTRL, 8'h03);
      wr(LXTC_OFS_AMP_CTRL, 8'h40);
      cal(LXTC_OFS_CMP0_TRIM, LXTC_OFS_CMP_CTRL, 8'h60, 6, 6'h1f, TH0);
      cal(LXTC_OFS_CMP1_TRIM, LXTC_OFS_CMP_CTRL, 8'h60, 7, 6'h1f, TH1);
      cal(LXTC_OFS_AMP_TRIM, LXTC_OFS_AMP_CTRL, 8'hc0, 5, 6'h3f, THA);
      // Amplifier status stays masked once calibration mode is left with a high output
      wr(LXTC_OFS_AMP_TRIM, 8'hff);
      repeat (8) @(posedge mclk);
      wr(LXTC_OFS_AMP_TRIM, 8'h7f);
      rd(LXTC_OFS_AMP_CTRL, 8'h40);
      // Shared output: comparator 0 high, comparator 1 low
      wr(LXTC_OFS_CMP0_TRIM, 8'h7f);
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      chk({7'h0, cmpSharedOut}, 8'h01);
      wr(LXTC_OFS_CMP_POLHYS, 8'h40);
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk({7'h0, cmpSharedOut}, 8'h00);
      // Inverted and disabled comparator 0
      wr(LXTC_OFS_CMP_POLHYS, 8'h50);
      wr(LXTC_OFS_CMP_CTRL, 8'h02);
      repeat (8) @(posedge mclk);
      peek(LXTC_OFS_CMP_CTRL, d);
      chk({6'h0, d[7:6]}, 8'h01);
      wr(LXTC_OFS_CMP_CTRL, 8'h03);
      repeat (8) @(posedge mclk);
      peek(LXTC_OFS_CMP_CTRL, d);
      chk({6'h0, d[7:6]}, 8'h00);
      // Each debounce period: filtered output waits for four agreeing samples
      wr(LXTC_OFS_CMP_POLHYS, 8'h00);
      for (int k = 1; k < 4; k++) begin
         debPeriod = (k == 1) ? LXTC_DEB_PER1 : (k == 2) ? LXTC_DEB_PER2 : LXTC_DEB_PER3;
         wr(LXTC_OFS_CMP0_TRIM, 8'h60);
         wr(LXTC_OFS_CMP_CTRL, 8'h03);
         repeat (12) @(posedge mclk);
         wr(LXTC_OFS_CMP_CTRL, {4'h0, 2'(k), 2'h3});
         wr(LXTC_OFS_CMP0_TRIM, 8'h7f);
         repeat (2 * debPeriod) @(posedge mclk);
         @(negedge mclk);
         chk({7'h0, cmpSharedOut}, 8'h00);
         repeat (2 * debPeriod + 12) @(posedge mclk);
         @(negedge mclk);
         chk({7'h0, cmpSharedOut}, 8'h01);
      end
      repeat (4) @(posedge mclk);
      stop_test();
   end
endmodule
